// ==== src/sled_top.sv ====
// Status indicator driver of a real-time Ethernet slave module.
// The state and error causes come from firmware logic on clk_sys and
// are used as they arrive. Link and activity come from the PHY pins and
// are synchronised before use. All indicator outputs are registered.
`timescale 1ns/1ps

module sled_top
    import sled_pkg::*;
#(
    // Clock cycles per millisecond; shorten in simulation.
    parameter int MS_CYCLES = MS_TICK_CYC
)
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire sled_slave_state_t slave_state,
    input  wire sled_err_t         err_cause,
    input  wire logic [NPORT-1:0]  link_up,
    input  wire logic [NPORT-1:0]  frame_act,
    output sled_duo_t              run_led,
    output sled_duo_t              err_led,
    output sled_port_led_t         port_led [NPORT]
);

    // ----------------------------------------------------------------
    // Millisecond tick.
    // ----------------------------------------------------------------

    // Last value of the divider, cut to the counter width.
    localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);
    // Divider reset value.
    localparam logic [MS_CNT_W-1:0] MS_ZERO = 17'h00000;

    // Divider counter.
    logic [MS_CNT_W-1:0] ms_cnt_r;
    // One-cycle pulse once per millisecond.
    logic                ms_tick_r;

    // The divider wraps on its last count.
    wire logic ms_wrap = (ms_cnt_r == MS_LAST);
    // Next divider value.
    wire logic [MS_CNT_W-1:0] ms_cnt_nxt =
        ms_wrap ? MS_ZERO : MS_CNT_W'(ms_cnt_r + 1'b1);

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ms_cnt_r  <= MS_ZERO;
            ms_tick_r <= 1'b0;
        end
        else
        begin
            ms_cnt_r  <= ms_cnt_nxt;
            ms_tick_r <= ms_wrap;
        end
    end

    // ----------------------------------------------------------------
    // Pattern selection for the state and error indicators.
    // ----------------------------------------------------------------

    // Map a slave state onto the pattern of the state indicator.
    function automatic sled_mode_t state_mode(input sled_slave_state_t st);
        sled_mode_t m;
        m = SLED_MODE_OFF;
        case (st)
            SLED_ST_INIT:   m = SLED_MODE_OFF;
            SLED_ST_PREOP:  m = SLED_MODE_BLINK;
            SLED_ST_SAFEOP: m = SLED_MODE_SINGLE;
            SLED_ST_OP:     m = SLED_MODE_ON;
            default:        m = SLED_MODE_OFF;
        endcase
        return m;
    endfunction

    // Map the error causes onto the pattern of the error indicator.
    // The watchdog outranks a local change, which outranks a bad
    // configuration, so the most urgent cause is the one shown.
    function automatic sled_mode_t err_mode(input sled_err_t e);
        sled_mode_t m;
        m = SLED_MODE_OFF;
        if (e.app_wdog)
            m = SLED_MODE_DOUBLE;
        else if (e.local_chg)
            m = SLED_MODE_SINGLE;
        else if (e.cfg_err)
            m = SLED_MODE_BLINK;
        else
            m = SLED_MODE_OFF;
        return m;
    endfunction

    // Pattern selected for the state indicator.
    wire sled_mode_t run_mode = state_mode(slave_state);
    // Pattern selected for the error indicator.
    wire sled_mode_t err_sel  = err_mode(err_cause);

    // Pattern level of the state indicator.
    logic run_lit;
    // Pattern level of the error indicator.
    logic err_lit;

    // Pattern generator for the state indicator.
    sled_pattern u_run_pat
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ms_tick (ms_tick_r),
        .mode    (run_mode),
        .lit     (run_lit)
    );

    // Pattern generator for the error indicator.
    sled_pattern u_err_pat
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ms_tick (ms_tick_r),
        .mode    (err_sel),
        .lit     (err_lit)
    );

    // Registered duo indicators.
    sled_duo_t run_led_r;
    sled_duo_t err_led_r;

    // The state indicator only ever shows green and the error indicator
    // only ever shows red; the other half of each duo stays dark.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            run_led_r <= '0;
            err_led_r <= '0;
        end
        else
        begin
            run_led_r.green <= run_lit;
            run_led_r.red   <= 1'b0;
            err_led_r.red   <= err_lit;
            err_led_r.green <= 1'b0;
        end
    end

    assign run_led = run_led_r;
    assign err_led = err_led_r;

    // ----------------------------------------------------------------
    // Port link/activity indicators.
    // ----------------------------------------------------------------

    // First and second synchroniser stages for link and activity.
    logic link_m_r [NPORT];
    logic link_s_r [NPORT];
    logic act_m_r  [NPORT];
    logic act_s_r  [NPORT];
    // Activity seen since the last flicker started.
    logic pend_r   [NPORT];
    // Flicker state per port.
    sled_flick_t fl_r [NPORT];
    // Milliseconds spent in the current flicker phase.
    logic [PH_CNT_W-1:0] fl_cnt_r [NPORT];
    // Registered port indicators.
    sled_port_led_t port_led_r [NPORT];

    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi = gi + 1)
        begin : g_port
            // The flicker phase ends on the tick closing its last ms.
            wire logic fl_done = ms_tick_r && (fl_cnt_r[gi] == FLICK_LAST);
            // A new flicker starts from idle when activity is pending.
            wire logic fl_start = (fl_r[gi] == SLED_FL_IDLE) && pend_r[gi];
            // A lit phase that ends with activity pending goes dark again.
            wire logic fl_again = (fl_r[gi] == SLED_FL_LIT) && fl_done
                                  && pend_r[gi];
            // Entering a dark phase consumes the pending activity.
            wire logic fl_take = fl_start || fl_again;
            // Green is lit in idle and lit phases while linked.
            wire logic green_nxt = link_s_r[gi] && (fl_r[gi] != SLED_FL_DARK);

            // Two-flop synchronisers for the PHY pins.
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                begin
                    link_m_r[gi] <= 1'b0;
                    link_s_r[gi] <= 1'b0;
                    act_m_r[gi]  <= 1'b0;
                    act_s_r[gi]  <= 1'b0;
                end
                else
                begin
                    link_m_r[gi] <= link_up[gi];
                    link_s_r[gi] <= link_m_r[gi];
                    act_m_r[gi]  <= frame_act[gi];
                    act_s_r[gi]  <= act_m_r[gi];
                end
            end

            // Pending activity: a new frame wins over the consume.
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                    pend_r[gi] <= 1'b0;
                else if (!link_s_r[gi])
                    pend_r[gi] <= 1'b0;
                else if (act_s_r[gi])
                    pend_r[gi] <= 1'b1;
                else if (fl_take)
                    pend_r[gi] <= 1'b0;
            end

            // load dependent flicker
            // Each burst of activity gives one dark then one lit phase
            // of FLICK_MS; steady traffic chains them into a 10 Hz
            // square wave, sparse traffic gives irregular blinks.
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                begin
                    fl_r[gi]     <= SLED_FL_IDLE;
                    fl_cnt_r[gi] <= PH_ZERO;
                end
                else if (!link_s_r[gi])
                begin
                    // Losing the link abandons any flicker in progress.
                    fl_r[gi]     <= SLED_FL_IDLE;
                    fl_cnt_r[gi] <= PH_ZERO;
                end
                else
                begin
                    case (fl_r[gi])
                        SLED_FL_IDLE:
                        begin
                            fl_cnt_r[gi] <= PH_ZERO;
                            if (fl_start)
                                fl_r[gi] <= SLED_FL_DARK;
                        end
                        SLED_FL_DARK:
                        begin
                            if (fl_done)
                            begin
                                fl_r[gi]     <= SLED_FL_LIT;
                                fl_cnt_r[gi] <= PH_ZERO;
                            end
                            else if (ms_tick_r)
                                fl_cnt_r[gi] <= PH_CNT_W'(fl_cnt_r[gi] + 1'b1);
                        end
                        SLED_FL_LIT:
                        begin
                            if (fl_done)
                            begin
                                fl_r[gi]     <= fl_again ? SLED_FL_DARK
                                                         : SLED_FL_IDLE;
                                fl_cnt_r[gi] <= PH_ZERO;
                            end
                            else if (ms_tick_r)
                                fl_cnt_r[gi] <= PH_CNT_W'(fl_cnt_r[gi] + 1'b1);
                        end
                        default:
                        begin
                            fl_r[gi]     <= SLED_FL_IDLE;
                            fl_cnt_r[gi] <= PH_ZERO;
                        end
                    endcase
                end
            end

            // Port indicator register.
            always_ff @(posedge clk_sys or posedge reset)
            begin
                if (reset)
                    port_led_r[gi] <= '0;
                else
                begin
                    port_led_r[gi].green  <= green_nxt;
                    port_led_r[gi].yellow <= 1'b0;
                end
            end

            assign port_led[gi] = port_led_r[gi];
        end
    endgenerate

endmodule

// ==== include/sled_pkg.sv ====
// Constants, types and carriers shared by the slave status indicator driver.
package sled_pkg;

    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;
    // Period of the millisecond tick in nanoseconds.
    localparam int MS_TICK_NS = 1000000;
    // Clock cycles per millisecond tick, derived from the two times above.
    localparam int MS_TICK_CYC = MS_TICK_NS / CLK_PERIOD_NS;
    // Width of the millisecond divider counter.
    localparam int MS_CNT_W = 17;

    // Pattern phase lengths in milliseconds.
    localparam int BLINK_MS      = 200;
    localparam int FLASH_ON_MS   = 200;
    localparam int FLASH_GAP_MS  = 200;
    localparam int FLASH_LONG_MS = 1000;
    localparam int FLICK_MS      = 50;

    // Width of the phase counter that counts milliseconds.
    localparam int PH_CNT_W = 10;
    // Last count value of each phase.
    localparam logic [PH_CNT_W-1:0] BLINK_LAST = PH_CNT_W'(BLINK_MS - 1);
    localparam logic [PH_CNT_W-1:0] SHORT_LAST = PH_CNT_W'(FLASH_ON_MS - 1);
    localparam logic [PH_CNT_W-1:0] GAP_LAST   = PH_CNT_W'(FLASH_GAP_MS - 1);
    localparam logic [PH_CNT_W-1:0] LONG_LAST  = PH_CNT_W'(FLASH_LONG_MS - 1);
    localparam logic [PH_CNT_W-1:0] FLICK_LAST = PH_CNT_W'(FLICK_MS - 1);
    // Phase counter start value.
    localparam logic [PH_CNT_W-1:0] PH_ZERO = 10'h000;

    // Number of Ethernet ports with a link/activity indicator.
    localparam int NPORT = 2;

    // Slave state machine state as reported by the protocol firmware.
    typedef enum logic [1:0] {
        SLED_ST_INIT   = 2'h0,
        SLED_ST_PREOP  = 2'h1,
        SLED_ST_SAFEOP = 2'h2,
        SLED_ST_OP     = 2'h3
    } sled_slave_state_t;

    // Indicator pattern selection.
    typedef enum logic [2:0] {
        SLED_MODE_OFF    = 3'h0,
        SLED_MODE_ON     = 3'h1,
        SLED_MODE_BLINK  = 3'h2,
        SLED_MODE_SINGLE = 3'h3,
        SLED_MODE_DOUBLE = 3'h4
    } sled_mode_t;

    // Phases of the pattern generator, one-hot.
    typedef enum logic [3:0] {
        SLED_PH_LIT1  = 4'h1,
        SLED_PH_DARK1 = 4'h2,
        SLED_PH_LIT2  = 4'h4,
        SLED_PH_LONG  = 4'h8
    } sled_phase_t;

    // States of the per-port activity flicker, one-hot.
    typedef enum logic [2:0] {
        SLED_FL_IDLE = 3'h1,
        SLED_FL_DARK = 3'h2,
        SLED_FL_LIT  = 3'h4
    } sled_flick_t;

    // Error causes reported by the protocol firmware.
    typedef struct packed {
        logic cfg_err;
        logic local_chg;
        logic app_wdog;
    } sled_err_t;

    // One red/green duo indicator.
    typedef struct packed {
        logic red;
        logic green;
    } sled_duo_t;

    // The two indicators of one Ethernet port.
    typedef struct packed {
        logic green;
        logic yellow;
    } sled_port_led_t;

endpackage

// ==== src/sled_pattern.sv ====
// Millisecond pattern generator for blinking, single flash and double flash.
`timescale 1ns/1ps

module sled_pattern
    import sled_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       ms_tick,
    input  wire sled_mode_t mode,
    output logic            lit
);

    // Current phase of the pattern.
    sled_phase_t           phase_r;
    // Next phase after the current one expires.
    sled_phase_t           phase_nxt;
    // Milliseconds spent in the current phase.
    logic [PH_CNT_W-1:0]   cnt_r;
    // Pattern that was selected in the previous cycle.
    sled_mode_t            mode_r;
    // Registered indicator level.
    logic                  lit_r;

    // A change of selection restarts the pattern at its first lit phase.
    wire logic restart = (mode != mode_r);
    // Last count of the current phase: blink, flash, short gap or long dark.
    wire logic [PH_CNT_W-1:0] last =
        (phase_r == SLED_PH_LONG)    ? LONG_LAST :
        (phase_r == SLED_PH_DARK1)   ? GAP_LAST  :
        (mode == SLED_MODE_BLINK)    ? BLINK_LAST : SHORT_LAST;
    // The phase ends on the tick that completes its last millisecond.
    wire logic expired = ms_tick && (cnt_r == last);
    // Lit during either flash phase.
    wire logic in_lit = (phase_r == SLED_PH_LIT1) || (phase_r == SLED_PH_LIT2);
    // Level of the indicator for the selected pattern; a restart shows the
    // first lit phase at once rather than the stale phase of the old pattern.
    wire logic lit_nxt = (mode == SLED_MODE_ON) ? 1'b1 :
                         (mode == SLED_MODE_OFF) ? 1'b0 : (restart || in_lit);
    // Phase counter advance.
    wire logic [PH_CNT_W-1:0] cnt_nxt =
        (restart || expired) ? PH_ZERO :
        ms_tick ? PH_CNT_W'(cnt_r + 1'b1) : cnt_r;

    // Phase sequencing per pattern.
    always_comb
    begin
        case (phase_r)
            SLED_PH_LIT1:
            begin
                if (mode == SLED_MODE_BLINK)
                    phase_nxt = SLED_PH_DARK1;
                else if (mode == SLED_MODE_SINGLE)
                    phase_nxt = SLED_PH_LONG;
                else
                    phase_nxt = SLED_PH_DARK1;
            end
            SLED_PH_DARK1:
            begin
                if (mode == SLED_MODE_DOUBLE)
                    phase_nxt = SLED_PH_LIT2;
                else
                    phase_nxt = SLED_PH_LIT1;
            end
            // The double flash closes with the long dark phase.
            SLED_PH_LIT2:  phase_nxt = SLED_PH_LONG;
            SLED_PH_LONG:  phase_nxt = SLED_PH_LIT1;
            default:       phase_nxt = SLED_PH_LIT1;
        endcase
    end

    // Phase, counter and output registers.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            phase_r <= SLED_PH_LIT1;
            cnt_r   <= PH_ZERO;
            mode_r  <= SLED_MODE_OFF;
            lit_r   <= 1'b0;
        end
        else
        begin
            mode_r <= mode;
            cnt_r  <= cnt_nxt;
            lit_r  <= lit_nxt;
            if (restart)
                phase_r <= SLED_PH_LIT1;
            else if (expired)
                phase_r <= phase_nxt;
        end
    end

    assign lit = lit_r;

endmodule

// ==== bench/sled_viewer.sv ====
// Operator model that measures the lit and dark runs of one indicator.
`timescale 1ns/1ps

module sled_viewer
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic led,
    output logic      run_done,
    output logic      run_lvl,
    output int        run_len
);
    logic lvl_r;  // Level being watched now.
    int   cnt_r;  // Samples seen at that level.

    // Close a run and report its length whenever the indicator changes level.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            lvl_r    <= 1'b0;
            cnt_r    <= 0;
            run_done <= 1'b0;
            run_lvl  <= 1'b0;
            run_len  <= 0;
        end
        else if (led !== lvl_r)
        begin
            run_done <= 1'b1;
            run_lvl  <= lvl_r;
            run_len  <= cnt_r;
            lvl_r    <= led;
            cnt_r    <= 1;
        end
        else
        begin
            run_done <= 1'b0;
            cnt_r    <= cnt_r + 1;
        end
    end
endmodule

// ==== bench/sled_chk.sv ====
// Concurrent checks on the ports of the status indicator driver.
`timescale 1ns/1ps

module sled_chk
    import sled_pkg::*;
#(
    parameter int MS_CYCLES = MS_TICK_CYC
)
(
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire sled_slave_state_t slave_state,
    input wire sled_err_t         err_cause,
    input wire logic [NPORT-1:0]  link_up,
    input wire logic [NPORT-1:0]  frame_act,
    input wire sled_duo_t         run_led,
    input wire sled_duo_t         err_led,
    input wire sled_port_led_t    port_led [NPORT]
);
    // Longest blink run, allowing the two-cycle hand-over from a lit level.
    localparam int BLINK_MAX = BLINK_MS * MS_CYCLES + 4;
    // Quiet time after which a linked port must be steady green again.
    localparam int IDLE_MIN = 2 * (2 * FLICK_MS + 1) * MS_CYCLES + 10;

    logic green_q_r;   // Run indicator green one cycle back.
    int   run_cnt_r;   // Cycles the run green level has held in pre-op.
    int   idle_cnt_r;  // Cycles port 0 has been linked and quiet.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Count the blink run length and the quiet time of port 0.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            green_q_r  <= 1'b0;
            run_cnt_r  <= 0;
            idle_cnt_r <= 0;
        end
        else
        begin
            green_q_r  <= run_led.green;
            run_cnt_r  <= (slave_state != SLED_ST_PREOP || run_led.green != green_q_r)
                          ? 0 : run_cnt_r + 1;
            idle_cnt_r <= (!link_up[0] || frame_act[0]) ? 0
                          : (idle_cnt_r < IDLE_MIN) ? idle_cnt_r + 1 : idle_cnt_r;
        end
    end

    // Init followed by pre-op, and no error followed by a watchdog report.
    sequence s_init_to_preop;
        slave_state == SLED_ST_INIT ##1 slave_state == SLED_ST_PREOP [*2];
    endsequence
    sequence s_clear_to_wdog;
        err_cause == 3'h0 ##1 err_cause == 3'h1 [*2];
    endsequence

    a_init_dark: assert property (slave_state == SLED_ST_INIT [*3] |-> !run_led.green)
        else $error("run indicator lit in init");
    a_op_steady: assert property (slave_state == SLED_ST_OP [*3] |-> run_led.green)
        else $error("run indicator not steady in op");
    a_noerr_dark: assert property (err_cause == 3'h0 [*3] |-> !err_led.red)
        else $error("error indicator lit without error");
    a_unused_off: assert property (!port_led[0].yellow && !port_led[1].yellow
        && !run_led.red && !err_led.green) else $error("unused indicator lit");
    a_nolink_off: assert property (!link_up[0] [*4] |-> !port_led[0].green)
        else $error("port green lit without link");
    a_idle_on: assert property (idle_cnt_r >= IDLE_MIN |-> port_led[0].green)
        else $error("quiet linked port not steady green");
    a_blink_len: assert property (slave_state == SLED_ST_PREOP |-> run_cnt_r < BLINK_MAX)
        else $error("blink phase too long");
    a_preop_start: assert property (s_init_to_preop |=> run_led.green)
        else $error("pre-op pattern did not start lit");
    a_wdog_start: assert property (s_clear_to_wdog |=> err_led.red)
        else $error("double flash did not start lit");
endmodule

bind sled_top sled_chk #(.MS_CYCLES(MS_CYCLES)) i_sled_chk (.clk_sys(clk_sys), .reset(reset),
    .slave_state(slave_state), .err_cause(err_cause), .link_up(link_up),
    .frame_act(frame_act), .run_led(run_led), .err_led(err_led), .port_led(port_led));

// ==== bench/test_sled_top.sv ====
// Self-checking testbench of the status indicator driver.
`timescale 1ns/1ps

module test_sled_top;
    import sled_pkg::*;

    localparam int MSC = 10;                  // Cycles per millisecond in this run.
    localparam int BL  = BLINK_MS * MSC;      // Short phase in cycles.
    localparam int LG  = FLASH_LONG_MS * MSC; // Long dark phase in cycles.
    localparam int FL  = FLICK_MS * MSC;      // Flicker phase in cycles.

    logic              clk_sys;
    logic              reset;
    sled_slave_state_t slave_state;
    sled_err_t         err_cause;
    logic [NPORT-1:0]  link_up;
    logic [NPORT-1:0]  frame_act;
    sled_duo_t         run_led;
    sled_duo_t         err_led;
    sled_port_led_t    port_led [NPORT];
    logic              vdone [3];  // Run closed, per watched indicator.
    logic              vlvl [3];   // Level of the closed run.
    int                vlen [3];   // Length of the closed run.
    int                n_fail;
    int                n_compared;

    sled_top #(.MS_CYCLES(MSC)) i_sled_top (.clk_sys(clk_sys), .reset(reset),
        .slave_state(slave_state), .err_cause(err_cause), .link_up(link_up),
        .frame_act(frame_act), .run_led(run_led), .err_led(err_led), .port_led(port_led));

    // Watchers for run green, error red and port 0 green.
    sled_viewer v_run (.clk_sys(clk_sys), .reset(reset), .led(run_led.green),
        .run_done(vdone[0]), .run_lvl(vlvl[0]), .run_len(vlen[0]));
    sled_viewer v_err (.clk_sys(clk_sys), .reset(reset), .led(err_led.red),
        .run_done(vdone[1]), .run_lvl(vlvl[1]), .run_len(vlen[1]));
    sled_viewer v_port (.clk_sys(clk_sys), .reset(reset), .led(port_led[0].green),
        .run_done(vdone[2]), .run_lvl(vlvl[2]), .run_len(vlen[2]));

    // The system clock, 10 ns period.
    always #5 clk_sys = ~clk_sys;

    // Print the counts and the verdict, then end the run.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Compare one value exactly, unknowns included.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
            n_fail++;
        end
    endtask

    // Compare a run length against a window.
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
            n_fail++;
        end
    endtask

    // Wait, bounded, for the next closed run of one indicator.
    task automatic next_run(input int k, output logic lvl, output int len);
        int i;
        for (i = 0; i < 20000; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (vdone[k] === 1'b1)
            begin
                lvl = vlvl[k];
                len = vlen[k];
                return;
            end
        end
        $display("CHECK FAILED run wait expected done seen timeout");
        n_fail++;
        report_and_stop();
    endtask

    // Skip to the first lit phase, check its length, then n following phases.
    task automatic check_pat(input int k, input int n, input int e0, e1, e2, e3);
        int   e [4];
        logic lv;
        int   ln;
        int   i;
        e = '{e0, e1, e2, e3};
        next_run(k, lv, ln);
        next_run(k, lv, ln);
        chk("first lit level", 1, lv);
        chk_rng("first lit length", BL - MSC, BL + 1, ln);
        for (i = 0; i < n; i++)
        begin
            next_run(k, lv, ln);
            chk("phase level", (i % 2 == 0) ? 0 : 1, lv);
            chk("phase length", e[i], ln);
        end
    endtask

    // Quiet inputs after reset leave every indicator dark.
    task automatic t_idle();
        repeat (20) @(posedge clk_sys);
        #1;
        chk("run green", 0, run_led.green);
        chk("err red", 0, err_led.red);
        chk("port0 green", 0, port_led[0].green);
        chk("port1 yellow", 0, port_led[1].yellow);
    endtask

    // Slave states: blink, single flash, steady, dark.
    task automatic t_states();
        @(posedge clk_sys);
        slave_state <= SLED_ST_PREOP;
        check_pat(0, 3, BL, BL, BL, 0);
        @(posedge clk_sys);
        slave_state <= SLED_ST_INIT;
        repeat (5) @(posedge clk_sys);
        chk("run green init", 0, run_led.green);
        slave_state <= SLED_ST_SAFEOP;
        check_pat(0, 2, LG, BL, 0, 0);
        @(posedge clk_sys);
        slave_state <= SLED_ST_OP;
        repeat (40)
        begin
            repeat (50) @(posedge clk_sys);
            #1;
            chk("run green op", 1, run_led.green);
        end
        @(posedge clk_sys);
        slave_state <= SLED_ST_INIT;
    endtask

    // Error causes: configuration, local change, application watchdog.
    task automatic t_errors();
        @(posedge clk_sys);
        err_cause <= 3'h4;
        check_pat(1, 2, BL, BL, 0, 0);
        @(posedge clk_sys);
        err_cause <= 3'h0;
        repeat (5) @(posedge clk_sys);
        chk("err red clear", 0, err_led.red);
        err_cause <= 3'h2;
        check_pat(1, 2, LG, BL, 0, 0);
        @(posedge clk_sys);
        err_cause <= 3'h0;
        repeat (5) @(posedge clk_sys);
        err_cause <= 3'h1;
        check_pat(1, 4, BL, BL, LG, BL);
        @(posedge clk_sys);
        err_cause <= 3'h0;
    endtask

    // Port link, single activity, steady traffic and link loss.
    task automatic t_port();
        logic lv;
        int   ln;
        @(posedge clk_sys);
        link_up <= 2'h1;
        repeat (5) @(posedge clk_sys);
        chk("port0 green link", 1, port_led[0].green);
        chk("port1 green nolink", 0, port_led[1].green);
        frame_act <= 2'h1;
        @(posedge clk_sys);
        frame_act <= 2'h0;
        next_run(2, lv, ln);
        next_run(2, lv, ln);
        chk("flicker dark level", 0, lv);
        chk_rng("flicker dark length", FL - MSC, FL + 1, ln);
        repeat (5 * FL) @(posedge clk_sys);
        chk("port0 green quiet", 1, port_led[0].green);
        frame_act <= 2'h1;
        next_run(2, lv, ln);
        next_run(2, lv, ln);
        next_run(2, lv, ln);
        chk("flicker lit length", FL, ln);
        next_run(2, lv, ln);
        chk("flicker dark steady", FL, ln);
        @(posedge clk_sys);
        link_up <= 2'h2;
        repeat (5) @(posedge clk_sys);
        chk("port0 green lost", 0, port_led[0].green);
        chk("port1 green link", 1, port_led[1].green);
        frame_act <= 2'h0;
    endtask

    // Main sequence: reset for five cycles, then every scenario.
    initial
    begin
        n_fail      = 0;
        n_compared  = 0;
        clk_sys     = 1'b0;
        reset       = 1'b1;
        slave_state = SLED_ST_INIT;
        err_cause   = 3'h0;
        link_up     = 2'h0;
        frame_act   = 2'h0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        t_idle();
        t_states();
        t_errors();
        t_port();
        report_and_stop();
    end
endmodule
